// File: common/tmcr_pkg.sv
// Constants, field layout and decode helpers for the terminal mode configuration register.
// Assumes a single 40 MHz core clock shared by the host port and the protocol engines.
//
// What this block does
// (RULE1) Bit 15 selects enhanced controller operation.
// (RULE2) Bit 14 clear: host waits message end.
// (RULE3) Bit 13 moves stack advance by four to end.
// (RULE4) Bit 12 enables global receive ring buffer.
// (RULE5) Bits 11-9: zero off, else 128..8192 words.
// (RULE6) Bit 8 drops queue entries for bad messages.
// (RULE7) Bit 7 drops queue entries for good messages.
// (RULE8) Bit 6 enables the interrupt status queue.
// (RULE9) Bit 5 clear: address and parity from pins.
// (RULE10) Bit 5 set: address from other register bits.
// (RULE11) Bit 4: combined monitor stores every word.
// (RULE12) Bit 2 expands register space; keep zero.
// (RULE13) Bits 1-0 declare input clock frequency.
// (RULE14) All bits reset zero, read back written.
`default_nettype none

package tmcr_pkg;

   // ****************************************
   // Register map and reset
   // ****************************************
   localparam logic [5:0]  TMCR_OFFSET = 6'h18;
   localparam logic [15:0] TMCR_RESET  = 16'h0000;

   // ****************************************
   // Timing
   // ****************************************
   localparam int CLK_PERIOD_NS = 25;
   // Whole message sequence the slow host path may wait for
   localparam int MSG_SEQ_NS    = 3600;
   localparam int MSG_WAIT_CYC  = MSG_SEQ_NS / CLK_PERIOD_NS;
   // Shortened wait with fast host access
   localparam int FAST_WAIT_NS  = 100;
   localparam int FAST_WAIT_CYC = FAST_WAIT_NS / CLK_PERIOD_NS;
   localparam logic [15:0] STACK_STEP = 16'h0004;

   // ****************************************
   // Field layout, bit 15 first
   // ****************************************
   typedef struct packed {
      logic       enhanced_controller_enable;
      logic       fast_host_access;
      logic       stack_advance_at_end;
      logic       global_ring_enable;
      logic [2:0] global_ring_size;
      logic       skip_queue_on_bad_msg;
      logic       skip_queue_on_good_msg;
      logic       irq_queue_enable;
      logic       term_addr_source;
      logic       monitor_store_all;
      logic       reserved;
      logic       extended_reg_space;
      logic [1:0] clock_freq_select;
   } tmcr_cfg_t;

   typedef enum logic [1:0] {TMCR_IDLE, TMCR_WAIT} tmcr_state_t;

   // Ring size in words, zero when the size code is zero
   function automatic logic [13:0] tmcr_ring_words(input logic [2:0] code);
      tmcr_ring_words = (code == 3'h0) ? 14'h0000 : 14'(14'h0040 << code);
   endfunction

   // Declared input clock in MHz
   function automatic logic [5:0] tmcr_clk_mhz(input logic [1:0] sel);
      case (sel)
         2'h0:    tmcr_clk_mhz = 6'h32;
         2'h1:    tmcr_clk_mhz = 6'h10;
         2'h2:    tmcr_clk_mhz = 6'h14;
         default: tmcr_clk_mhz = 6'h28;
      endcase
   endfunction

endpackage

`default_nettype wire

// File: hw/tmcr_core.sv
// Terminal mode configuration register and the small pieces of logic it steers directly.
// Assumes host strobes and protocol events are synchronous to core_clk_in; address pins are not.
`default_nettype none

module tmcr_core
   import tmcr_pkg::*;
(
   input  wire logic        core_clk_in,
   input  wire logic        rst_in,
   input  wire logic        host_wr_in,
   input  wire logic        host_rd_in,
   input  wire logic [5:0]  host_addr_in,
   input  wire logic [15:0] host_wdata_in,
   input  wire logic        host_req_in,
   input  wire logic        msg_active_in,
   input  wire logic        message_begin_in,
   input  wire logic        message_end_in,
   input  wire logic        term_mode_in,
   input  wire logic        combo_mode_in,
   input  wire logic        msg_irq_in,
   input  wire logic        msg_valid_in,
   input  wire logic [4:0]  term_addr_pins_in,
   input  wire logic        term_addr_parity_pin_in,
   input  wire logic [5:0]  alt_addr_in,
   input  wire logic        word_strobe_in,
   input  wire logic        word_is_status_in,
   output var  logic [15:0] host_rdata_out,
   output var  logic        host_rvalid_out,
   output var  logic        host_grant_out,
   output var  tmcr_cfg_t   cfg_out,
   output var  logic        queue_write_out,
   output var  logic [15:0] stack_ptr_out,
   output var  logic [4:0]  term_addr_out,
   output var  logic        term_addr_parity_out,
   output var  logic        store_word_out,
   output var  logic        ring_active_out,
   output var  logic [13:0] ring_words_out,
   output var  logic [5:0]  clk_mhz_out
);

   // ****************************************
   // Register file
   // ****************************************
   tmcr_cfg_t   next_cfg;
   logic [15:0] next_rdata;
   logic        next_rvalid;
   logic        hit;

   // Single register at one address; unmapped reads return zero
   always_comb
   begin
      hit         = (host_addr_in == TMCR_OFFSET);
      next_cfg    = cfg_out;
      next_rdata  = 16'h0000;
      next_rvalid = host_rd_in;
      if (host_wr_in && hit)
      begin
         next_cfg = tmcr_cfg_t'(host_wdata_in); // RULE1 RULE12 RULE14
      end
      if (host_rd_in && hit)
      begin
         next_rdata = 16'(cfg_out); // RULE14
      end
   end

   always_ff @(posedge core_clk_in)
   begin
      if (rst_in)
      begin
         cfg_out         <= tmcr_cfg_t'(TMCR_RESET); // RULE14
         host_rdata_out  <= 16'h0000;
         host_rvalid_out <= 1'b0;
      end
      else
      begin
         cfg_out         <= next_cfg;
         host_rdata_out  <= next_rdata;
         host_rvalid_out <= next_rvalid;
      end
   end

   // ****************************************
   // Decoded fields
   // ****************************************
   logic        next_ring_active;
   logic [13:0] next_ring_words;
   logic [5:0]  next_clk_mhz;

   // Size code zero turns the ring off even with the enable set
   always_comb
   begin
      next_ring_words  = tmcr_ring_words(cfg_out.global_ring_size); // RULE5
      next_ring_active = cfg_out.global_ring_enable && (cfg_out.global_ring_size != 3'h0); // RULE4
      next_clk_mhz     = tmcr_clk_mhz(cfg_out.clock_freq_select); // RULE13
   end

   always_ff @(posedge core_clk_in)
   begin
      if (rst_in)
      begin
         ring_words_out  <= 14'h0000;
         ring_active_out <= 1'b0;
         clk_mhz_out     <= 6'h00;
      end
      else
      begin
         ring_words_out  <= next_ring_words;
         ring_active_out <= next_ring_active;
         clk_mhz_out     <= next_clk_mhz;
      end
   end

   // ****************************************
   // Host access arbitration
   // ****************************************
   tmcr_state_t state;
   tmcr_state_t next_state;
   logic [7:0]  wait_cnt;
   logic [7:0]  next_wait_cnt;
   logic        next_grant;
   logic        wait_done;

   // Slow path waits out the message, capped at one full sequence so a stuck
   // message flag cannot starve the host forever
   always_comb
   begin
      next_state    = state;
      next_wait_cnt = wait_cnt;
      next_grant    = 1'b0;
      wait_done     = !msg_active_in
                      || (cfg_out.fast_host_access && (wait_cnt >= 8'(FAST_WAIT_CYC - 1))) // RULE2
                      || (wait_cnt >= 8'(MSG_WAIT_CYC - 1)); // RULE2
      case (state)
         TMCR_IDLE:
         begin
            if (host_req_in && !msg_active_in)
            begin
               next_grant = 1'b1;
            end
            else if (host_req_in)
            begin
               next_state    = TMCR_WAIT;
               next_wait_cnt = 8'h00;
            end
         end
         TMCR_WAIT:
         begin
            next_wait_cnt = wait_cnt + 8'h01;
            if (wait_done)
            begin
               next_grant = 1'b1;
               next_state = TMCR_IDLE;
            end
         end
         default:
         begin
            next_state = TMCR_IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk_in)
   begin
      if (rst_in)
      begin
         state          <= TMCR_IDLE;
         wait_cnt       <= 8'h00;
         host_grant_out <= 1'b0;
      end
      else
      begin
         state          <= next_state;
         wait_cnt       <= next_wait_cnt;
         host_grant_out <= next_grant;
      end
   end

   // ****************************************
   // Stack pointer, queue gating, monitor storage
   // ****************************************
   logic [15:0] next_stack_ptr;
   logic        next_queue_write;
   logic        next_store_word;
   logic        stack_event;

   always_comb
   begin
      stack_event      = cfg_out.stack_advance_at_end ? message_end_in : message_begin_in; // RULE3
      next_stack_ptr   = stack_ptr_out;
      if (term_mode_in && stack_event)
      begin
         next_stack_ptr = stack_ptr_out + STACK_STEP; // RULE3
      end
      next_queue_write = cfg_out.irq_queue_enable && msg_irq_in // RULE8
                         && !(msg_valid_in && cfg_out.skip_queue_on_good_msg) // RULE7
                         && !(!msg_valid_in && cfg_out.skip_queue_on_bad_msg); // RULE6
      // Outside combined mode the monitor engine decides on its own
      next_store_word  = word_strobe_in
                         && (!combo_mode_in || !word_is_status_in || cfg_out.monitor_store_all); // RULE11
   end

   always_ff @(posedge core_clk_in)
   begin
      if (rst_in)
      begin
         stack_ptr_out   <= 16'h0000;
         queue_write_out <= 1'b0;
         store_word_out  <= 1'b0;
      end
      else
      begin
         stack_ptr_out   <= next_stack_ptr;
         queue_write_out <= next_queue_write;
         store_word_out  <= next_store_word;
      end
   end

   // ****************************************
   // Terminal address source
   // ****************************************
   logic [5:0] pin_s1;
   logic [5:0] pin_s2;
   logic [5:0] pin_s3;
   logic [5:0] pin_stable;
   logic [5:0] next_pin_stable;
   logic [5:0] next_addr;

   // Pins are strapped asynchronously; a change counts once two stages agree
   always_comb
   begin
      next_pin_stable = (pin_s2 == pin_s3) ? pin_s3 : pin_stable;
      next_addr       = cfg_out.term_addr_source ? alt_addr_in : next_pin_stable; // RULE9 RULE10
   end

   always_ff @(posedge core_clk_in)
   begin
      if (rst_in)
      begin
         pin_s1               <= 6'h00;
         pin_s2               <= 6'h00;
         pin_s3               <= 6'h00;
         pin_stable           <= 6'h00;
         term_addr_out        <= 5'h00;
         term_addr_parity_out <= 1'b0;
      end
      else
      begin
         pin_s1               <= {term_addr_pins_in, term_addr_parity_pin_in};
         pin_s2               <= pin_s1;
         pin_s3               <= pin_s2;
         pin_stable           <= next_pin_stable;
         term_addr_out        <= next_addr[5:1];
         term_addr_parity_out <= next_addr[0];
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (rst_in);

   sequence s_reg_write;
      host_wr_in && (host_addr_in == TMCR_OFFSET);
   endsequence

   sequence s_reg_read;
      host_rd_in && (host_addr_in == TMCR_OFFSET);
   endsequence

   a_write_read_back: assert property ( // RULE14
      s_reg_write ##1 s_reg_read |=> (host_rdata_out == $past(host_wdata_in, 2)))
      else $error("register read does not return written value");

   a_reset_clears_reg: assert property (disable iff (1'b0) // RULE14
      rst_in |=> (16'(cfg_out) == TMCR_RESET))
      else $error("register not cleared by reset");

   a_ring_size_map: assert property ( // RULE5
      ##1 (ring_words_out == tmcr_ring_words($past(cfg_out.global_ring_size))))
      else $error("ring size decode wrong");

   a_ring_enable_off: assert property ( // RULE4
      !cfg_out.global_ring_enable |=> !ring_active_out)
      else $error("ring active while disabled");

   a_clock_decode: assert property ( // RULE13
      (cfg_out.clock_freq_select == 2'h1) && $stable(cfg_out) |=> (clk_mhz_out == 6'h10))
      else $error("clock select decode wrong");

   a_skip_bad_msg: assert property ( // RULE6
      cfg_out.skip_queue_on_bad_msg && !msg_valid_in |=> !queue_write_out)
      else $error("bad message entered queue");

   a_skip_good_msg: assert property ( // RULE7
      cfg_out.skip_queue_on_good_msg && msg_valid_in |=> !queue_write_out)
      else $error("good message entered queue");

   a_queue_enable: assert property ( // RULE8
      !cfg_out.irq_queue_enable |=> !queue_write_out)
      else $error("queue written while disabled");

   a_stack_at_end: assert property ( // RULE3
      term_mode_in && cfg_out.stack_advance_at_end && message_end_in
      |=> (stack_ptr_out == $past(stack_ptr_out) + STACK_STEP))
      else $error("stack pointer did not advance at message end");

   a_stack_not_begin: assert property ( // RULE3
      cfg_out.stack_advance_at_end && !message_end_in |=> $stable(stack_ptr_out))
      else $error("stack pointer moved at message begin");

   a_alt_addr_use: assert property ( // RULE10
      cfg_out.term_addr_source |=> ({term_addr_out, term_addr_parity_out} == $past(alt_addr_in)))
      else $error("alternate address not used");

   a_fast_grant: assert property ( // RULE2
      (state == TMCR_IDLE) && host_req_in && msg_active_in && cfg_out.fast_host_access
      ##1 (cfg_out.fast_host_access && msg_active_in) [*4] |=> host_grant_out)
      else $error("fast host access not granted in time");

   a_slow_grant_wait: assert property ( // RULE2
      (state == TMCR_WAIT) && !cfg_out.fast_host_access && msg_active_in
      && (wait_cnt < 8'(MSG_WAIT_CYC - 1)) |=> !host_grant_out)
      else $error("host granted during message");

   a_store_all: assert property ( // RULE11
      word_strobe_in && combo_mode_in && cfg_out.monitor_store_all |=> store_word_out)
      else $error("monitor dropped a word");

endmodule

`default_nettype wire

// File: sim/test_terminal_mode_config_register.sv
// Self-checking bench for the terminal mode configuration register core.
// Assumes tmcr_pkg and hw/tmcr_core are compiled first; one 40 MHz clock.
`default_nettype none

module test_terminal_mode_config_register
   import tmcr_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;

   // ****************************************
   // Stimulus and observed signals
   // ****************************************
   logic        clk  = 1'b0;
   logic        rst  = 1'b1;
   logic        wr   = 1'b0;
   logic        rd   = 1'b0;
   logic        req  = 1'b0;
   logic        act  = 1'b0;
   logic        mb   = 1'b0;
   logic        me   = 1'b0;
   logic        tm   = 1'b0;
   logic        cm   = 1'b0;
   logic        irq  = 1'b0;
   logic        val  = 1'b0;
   logic        par  = 1'b0;
   logic        ws   = 1'b0;
   logic        st   = 1'b0;
   logic [5:0]  addr = 6'h00;
   logic [5:0]  alt  = 6'h00;
   logic [15:0] wd   = 16'h0000;
   logic [4:0]  pins = 5'h00;
   logic [15:0] rdata;
   logic        rvalid;
   logic        grant;
   tmcr_cfg_t   cfg;
   logic        qw;
   logic [15:0] sp;
   logic [4:0]  ta;
   logic        tap;
   logic        sw;
   logic        ra;
   logic [13:0] rw;
   logic [5:0]  mhz;
   int          n_mismatch = 0;
   int          tests_run  = 0;

   tmcr_core i_dut (
      .core_clk_in(clk), .rst_in(rst), .host_wr_in(wr), .host_rd_in(rd), .host_addr_in(addr),
      .host_wdata_in(wd), .host_req_in(req), .msg_active_in(act), .message_begin_in(mb),
      .message_end_in(me), .term_mode_in(tm), .combo_mode_in(cm), .msg_irq_in(irq),
      .msg_valid_in(val), .term_addr_pins_in(pins), .term_addr_parity_pin_in(par),
      .alt_addr_in(alt), .word_strobe_in(ws), .word_is_status_in(st), .host_rdata_out(rdata),
      .host_rvalid_out(rvalid), .host_grant_out(grant), .cfg_out(cfg), .queue_write_out(qw),
      .stack_ptr_out(sp), .term_addr_out(ta), .term_addr_parity_out(tap), .store_word_out(sw),
      .ring_active_out(ra), .ring_words_out(rw), .clk_mhz_out(mhz)
   );

   // Free-running 40 MHz clock
   initial
   begin
      forever #12.5 clk = ~clk;
   end

   // ****************************************
   // Helpers
   // ****************************************
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      tests_run++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic report_and_stop();
      $display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // One-cycle write strobe; the new value is on cfg_out after that edge
   task automatic wr_reg(input logic [5:0] a, input logic [15:0] d);
      @(posedge clk);
      wr   <= 1'b1;
      addr <= a;
      wd   <= d;
      @(posedge clk);
      wr <= 1'b0;
      #1;
   endtask

   // Read and compare; reads of other addresses still answer with valid
   task automatic rd_reg(input logic [5:0] a, input logic [15:0] e);
      @(posedge clk);
      rd   <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk("rvalid", 16'h0001, {15'h0000, rvalid});
      chk("rdata", e, rdata);
   endtask

   // Event pulses: irq, message begin, message end, word strobe
   task automatic pulse(input logic [3:0] k);
      @(posedge clk);
      irq <= k[3];
      mb  <= k[2];
      me  <= k[1];
      ws  <= k[0];
      @(posedge clk);
      {irq, mb, me, ws} <= 4'h0;
      #1;
   endtask

   task automatic wait_cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   // Bounded wait for the one-cycle grant pulse
   task automatic wait_grant(input int lim, output logic seen);
      seen = 1'b0;
      for (int n = 0; n < lim && !seen; n++)
      begin
         @(posedge clk);
         #1;
         seen = (grant === 1'b1);
      end
   endtask

   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_readback();
      chk("cfg reset", 16'h0000, cfg);
      rd_reg(6'h18, 16'h0000);
      wr_reg(6'h18, 16'hFFFF);
      chk("cfg all", 16'hFFFF, cfg);
      rd_reg(6'h18, 16'hFFFF);
      wr_reg(6'h18, 16'hA5C3);
      wr_reg(6'h19, 16'h0000);
      rd_reg(6'h18, 16'hA5C3);
      rd_reg(6'h19, 16'h0000);
      // Second reset mid-run must clear every field again
      @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      wait_cyc(1);
      chk("cfg rerst", 16'h0000, cfg);
   endtask

   task automatic t_ring();
      logic [15:0] e;
      for (int c = 0; c < 8; c++)
      begin
         wr_reg(6'h18, 16'h1000 | (16'(c) << 9));
         wait_cyc(2);
         e = (c == 0) ? 16'h0000 : (16'h0080 << (c - 1));
         chk("ring words", e, {2'h0, rw});
         chk("ring on", {15'h0000, c != 0}, {15'h0000, ra});
      end
      wr_reg(6'h18, 16'h0E00);
      wait_cyc(2);
      chk("ring off", 16'h0000, {15'h0000, ra});
   endtask

   task automatic t_clock();
      logic [5:0] tbl[4] = '{6'h32, 6'h10, 6'h14, 6'h28};
      for (int c = 3; c >= 0; c--)
      begin
         wr_reg(6'h18, 16'(c));
         wait_cyc(2);
         chk("clk mhz", {10'h000, tbl[c]}, {10'h000, mhz});
      end
   endtask

   // Every combination of enable, both skip bits and message validity
   task automatic t_queue();
      logic [3:0] b;
      logic       e;
      for (int i = 0; i < 16; i++)
      begin
         b = 4'(i);
         wr_reg(6'h18, {7'h00, b[1], b[2], b[0], 6'h00});
         @(posedge clk);
         val <= b[3];
         @(posedge clk);
         irq <= 1'b1;
         @(posedge clk);
         irq <= 1'b0;
         #1;
         e = b[0] & ~(b[3] ? b[2] : b[1]);
         chk("queue write", {15'h0000, e}, {15'h0000, qw});
      end
   endtask

   task automatic t_addr();
      wr_reg(6'h18, 16'h0000);
      @(posedge clk);
      pins <= 5'h15;
      par  <= 1'b1;
      alt  <= 6'h0E;
      wait_cyc(6);
      chk("addr pins", {10'h000, 5'h15, 1'b1}, {10'h000, ta, tap});
      wr_reg(6'h18, 16'h0020);
      wait_cyc(2);
      chk("addr reg", {10'h000, 6'h0E}, {10'h000, ta, tap});
   endtask

   task automatic t_stack();
      logic [15:0] s;
      @(posedge clk);
      tm <= 1'b1;
      wr_reg(6'h18, 16'h0000);
      s = sp;
      pulse(4'h4);
      chk("stack begin", s + 16'h0004, sp);
      pulse(4'h2);
      chk("stack end", s + 16'h0004, sp);
      wr_reg(6'h18, 16'h2000);
      pulse(4'h4);
      chk("stack begin", s + 16'h0004, sp);
      pulse(4'h2);
      chk("stack end", s + 16'h0008, sp);
      // Outside terminal mode the pointer stays put
      @(posedge clk);
      tm <= 1'b0;
      pulse(4'h6);
      chk("stack idle", s + 16'h0008, sp);
   endtask

   task automatic t_store();
      @(posedge clk);
      cm <= 1'b1;
      st <= 1'b1;
      wr_reg(6'h18, 16'h0000);
      pulse(4'h1);
      chk("store status", 16'h0000, {15'h0000, sw});
      wr_reg(6'h18, 16'h0010);
      pulse(4'h1);
      chk("store all", 16'h0001, {15'h0000, sw});
   endtask

   task automatic t_grant();
      logic seen;
      wr_reg(6'h18, 16'h0000);
      @(posedge clk);
      act <= 1'b1;
      req <= 1'b1;
      @(posedge clk);
      req <= 1'b0;
      wait_grant(20, seen);
      chk("slow early", 16'h0000, {15'h0000, seen});
      @(posedge clk);
      act <= 1'b0;
      wait_grant(4, seen);
      chk("slow grant", 16'h0001, {15'h0000, seen});
      wr_reg(6'h18, 16'h4000);
      @(posedge clk);
      act <= 1'b1;
      req <= 1'b1;
      @(posedge clk);
      req <= 1'b0;
      wait_grant(10, seen);
      chk("fast grant", 16'h0001, {15'h0000, seen});
      @(posedge clk);
      act <= 1'b0;
   endtask

   // ****************************************
   // Main sequence and watchdog
   // ****************************************
   initial
   begin
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      wait_cyc(1);
      t_readback();
      t_ring();
      t_clock();
      t_queue();
      t_addr();
      t_stack();
      t_store();
      t_grant();
      report_and_stop();
   end

   // About 230 cycles are needed; a hang is cut off well beyond that
   initial
   begin
      #(25 * 4000);
      n_mismatch++;
      report_and_stop();
   end

endmodule

`default_nettype wire
